/* File: include/drps_defines.vh */
// Constants for the waveform-memory profile sequencer: offsets, fields, modes.
// Assumes inclusion by bare name from the design file; definitions only.
// Summary of operation
// - With sweep enable clear, four consecutive registers are the four segment words.
// - Sixteen-bit ramp rate sets cycles per address; zero is invalid.
// - End address is word bits 9:8 above word bits 23:16.
// - Start address is word bits 3:0 above word bits 15:10.
// - Three-bit mode field per segment; only defined codes are meaningful.
// - No-dwell clear holds ramp up at end; set returns it to start and stays.
// - Single-port 1024 by 32 memory, never read and write together.
// - Serial writes beat reads; a write stops any read in progress.
// - Memory enable set routes output by destination bit; 1 phase, 0 frequency.
// - Unused destination is fed from the phase or frequency word register.
// - Memory enable clear keeps memory idle except writes; reset is single tone.
// - Profile pins pick one of four segments and its control word.
// - A memory write during operation stops readout until restarted.
// - Loading writes words in order from segment start to end address.
// - Single tone feeds the tuning word; changes take effect one cycle after the register write.
// - Direct switch reads only the start address, no stepping, ignores no-dwell.
// - Direct switch profile change loads new tuning word without clearing accumulator.
// - Phase destination uses memory bits 31:18, ignores bits 17:0.
// - Ramp up loads start and timer on update or profile change, steps on expiry.
// - Ramp up without no-dwell stops at end until update or profile change.
// - Ramp up with no-dwell clears accumulator one period after end, held.
// - Update, or profile change outside the bidirectional ramp, aborts the sweep and restarts it.
// - Mode 010 in segment 0 is bidirectional; profile 0 is direction.
`ifndef DRPS_DEFINES_VH
`define DRPS_DEFINES_VH
`define DRPS_ADDR_FTW 8'h04
`define DRPS_ADDR_POW 8'h05
`define DRPS_ADDR_SCW0 8'h07
`define DRPS_ADDR_SCW3 8'h0a
`define DRPS_ADDR_MEM 8'h0b
`define DRPS_CTL_MEM_EN 31
`define DRPS_CTL_DEST 30
`define DRPS_CTL_SWEEP_EN 21
`define DRPS_RATE_HI 39
`define DRPS_RATE_LO 24
`define DRPS_MODE_HI 7
`define DRPS_MODE_LO 5
`define DRPS_NODWELL 4
`define DRPS_MODE_DIRECT 3'h0
`define DRPS_MODE_RAMPUP 3'h1
`define DRPS_MODE_BIDIR 3'h2
`define DRPS_MODE_CONTBI 3'h3
`define DRPS_MODE_RECIRC 3'h4
`define DRPS_MEM_DEPTH 1024
`define DRPS_SEGMENTS 4
`define DRPS_END_TOP_HI 9
`define DRPS_END_TOP_LO 8
`define DRPS_END_LOW_HI 23
`define DRPS_END_LOW_LO 16
`define DRPS_START_TOP_HI 3
`define DRPS_START_TOP_LO 0
`define DRPS_START_LOW_HI 15
`define DRPS_START_LOW_LO 10
`define DRPS_PHASE_HI 31
`define DRPS_PHASE_LO 18
`define DRPS_SCW_RESET 40'h0000000000
`define DRPS_TIMER_RESET 16'h0001
`define DRPS_TIMER_LAST 16'h0001
`define DRPS_FTW_RESET 32'h00000000
`define DRPS_POW_RESET 14'h0000
`endif

/* File: src/drps_sequencer.v */
// Waveform-memory sequencer: segment words, 1024x32 memory, sweep address engine.
// Assumes a serial-port front end that delivers decoded register and memory writes.
`timescale 1ns/1ps
`include "drps_defines.vh"
module drps_sequencer (
	// Clock and reset
	input wire clock_i,
	input wire srst_i,
	// Decoded serial register writes
	input wire reg_wr_i,
	input wire [7:0] reg_addr_i,
	input wire [39:0] reg_wdata_i,
	input wire [31:0] primary_control_register_i,
	// Update strobe and profile select pins
	input wire io_update_i,
	input wire [1:0] profile_select_pins_i,
	// Core outputs
	output reg [31:0] tuning_word_o,
	output reg [13:0] phase_word_o,
	output reg acc_clear_o,
	output reg [9:0] mem_addr_o,
	output reg mem_reading_o,
	output reg [1:0] segment_o,
	output reg load_done_o
);
	// Address generator states
	localparam ST_IDLE = 2'd0;
	localparam ST_RUN = 2'd1;
	localparam ST_DWELL = 2'd2;
	localparam ST_CLEAR = 2'd3;

	// Tuning and phase words, waveform memory
	reg [31:0] ftw_q;
	reg [13:0] pow_q;
	reg [31:0] mem [0:`DRPS_MEM_DEPTH-1];
	reg [31:0] mem_rd_q;

	// Profile pin synchroniser stages
	reg [1:0] ps_s1_q;
	reg [1:0] ps_s2_q;
	reg [1:0] ps_prev_q;

	// Sweep engine registers and next values
	reg [1:0] state_q;
	reg [1:0] state_d;
	reg [9:0] addr_q;
	reg [9:0] addr_d;
	reg [15:0] timer_q;
	reg [15:0] timer_d;
	reg acc_clear_d;

	// Load pointer and read pipeline
	reg [9:0] wr_addr_q;
	reg [9:0] wr_addr_d;
	reg load_done_d;
	reg halted_q;
	reg rd_valid_q;
	reg out_valid_q;

	// Output routing next values
	reg [31:0] tuning_word_d;
	reg [13:0] phase_word_d;

	// Fields of all four segments, packed per segment
	wire [39:0] end_all;
	wire [39:0] start_all;
	wire [63:0] rate_all;
	wire [11:0] mode_all;
	wire [3:0] no_dwell_all;
	genvar g;

	// Control register bits
	wire mem_en = primary_control_register_i[`DRPS_CTL_MEM_EN];
	wire dest_phase = primary_control_register_i[`DRPS_CTL_DEST];
	wire seg_mode = ~primary_control_register_i[`DRPS_CTL_SWEEP_EN];
	wire mem_wr = reg_wr_i && (reg_addr_i == `DRPS_ADDR_MEM);

	// Active segment follows the synchronised pins
	wire [1:0] seg = ps_s2_q;
	wire [9:0] end_addr = end_all[seg*10 +: 10];
	wire [9:0] start_addr = start_all[seg*10 +: 10];
	wire [15:0] rate = rate_all[seg*16 +: 16];
	wire [2:0] mode_raw = mode_all[seg*3 +: 3];
	wire no_dwell = no_dwell_all[seg];

	// Segment 0 fields, used by the bidirectional ramp
	wire [9:0] end0 = end_all[9:0];
	wire [9:0] start0 = start_all[9:0];
	wire bidir = (mode_all[2:0] == `DRPS_MODE_BIDIR);

	// Sweep triggers; in the bidirectional ramp profile 0 steers, never restarts
	wire ps_change = bidir ? 1'b0 : (ps_s2_q != ps_prev_q);
	wire restart = io_update_i | ps_change;
	wire tick = (timer_q == `DRPS_TIMER_LAST);
	wire dir_up = ps_s2_q[0];

	// Effective mode; open codes fall back to direct switch
	reg [2:0] mode;
	always @* begin
		mode = `DRPS_MODE_DIRECT;
		if (bidir) begin
			mode = `DRPS_MODE_BIDIR;
		end else begin
			case (mode_raw)
			`DRPS_MODE_DIRECT: mode = `DRPS_MODE_DIRECT;
			`DRPS_MODE_RAMPUP: mode = `DRPS_MODE_RAMPUP;
			`DRPS_MODE_BIDIR: mode = `DRPS_MODE_BIDIR;
			`DRPS_MODE_CONTBI: mode = `DRPS_MODE_CONTBI;
			`DRPS_MODE_RECIRC: mode = `DRPS_MODE_RECIRC;
			default: mode = `DRPS_MODE_DIRECT;
			endcase
		end
	end

	// Segment word registers and field decode, one block per segment
	generate
		for (g = 0; g < `DRPS_SEGMENTS; g = g + 1) begin : g_seg
			localparam [31:0] SEG_OFS = `DRPS_ADDR_SCW0 + g;
			localparam [7:0] SEG_ADDR = SEG_OFS[7:0];
			reg [39:0] word_q;

			// Word write, refused while sweep enable is set
			always @(posedge clock_i) begin
				if (srst_i) begin
					word_q <= `DRPS_SCW_RESET;
				end else if (reg_wr_i && seg_mode && (reg_addr_i == SEG_ADDR)) begin
					word_q <= reg_wdata_i;
				end
			end

			// Split address fields joined back together
			assign end_all[g*10 +: 10] = {word_q[`DRPS_END_TOP_HI:`DRPS_END_TOP_LO],
				word_q[`DRPS_END_LOW_HI:`DRPS_END_LOW_LO]};
			assign start_all[g*10 +: 10] = {word_q[`DRPS_START_TOP_HI:`DRPS_START_TOP_LO],
				word_q[`DRPS_START_LOW_HI:`DRPS_START_LOW_LO]};
			assign rate_all[g*16 +: 16] = word_q[`DRPS_RATE_HI:`DRPS_RATE_LO];
			assign mode_all[g*3 +: 3] = word_q[`DRPS_MODE_HI:`DRPS_MODE_LO];
			assign no_dwell_all[g] = word_q[`DRPS_NODWELL];
		end
	endgenerate

	// Profile pin synchroniser and change detector
	always @(posedge clock_i) begin
		if (srst_i) begin
			ps_s1_q <= 2'h0;
			ps_s2_q <= 2'h0;
			ps_prev_q <= 2'h0;
		end else begin
			ps_s1_q <= profile_select_pins_i;
			ps_s2_q <= ps_s1_q;
			ps_prev_q <= ps_s2_q;
		end
	end

	// Frequency tuning word register
	always @(posedge clock_i) begin
		if (srst_i) begin
			ftw_q <= `DRPS_FTW_RESET;
		end else if (reg_wr_i && (reg_addr_i == `DRPS_ADDR_FTW)) begin
			ftw_q <= reg_wdata_i[31:0];
		end
	end

	// Phase offset word register
	always @(posedge clock_i) begin
		if (srst_i) begin
			pow_q <= `DRPS_POW_RESET;
		end else if (reg_wr_i && (reg_addr_i == `DRPS_ADDR_POW)) begin
			pow_q <= reg_wdata_i[13:0];
		end
	end

	// Load pointer walks start to end of the selected segment, then wraps
	always @* begin
		wr_addr_d = wr_addr_q;
		load_done_d = 1'b0;
		if (mem_wr) begin
			if (wr_addr_q == end_addr) begin
				wr_addr_d = start_addr;
				load_done_d = 1'b1;
			end else begin
				wr_addr_d = wr_addr_q + 10'd1;
			end
		end else if (restart) begin
			wr_addr_d = start_addr;
		end
	end

	// Load pointer registers
	always @(posedge clock_i) begin
		if (srst_i) begin
			wr_addr_q <= 10'h000;
			load_done_o <= 1'b0;
		end else begin
			wr_addr_q <= wr_addr_d;
			load_done_o <= load_done_d;
		end
	end

	// Single port: a write always wins, a read only when enabled and not halted
	always @(posedge clock_i) begin
		if (mem_wr) begin
			mem[wr_addr_q] <= reg_wdata_i[31:0];
		end else if (mem_en && !halted_q) begin
			mem_rd_q <= mem[addr_q];
		end
	end

	// Halt flag; a write wins over a restart in the same cycle
	always @(posedge clock_i) begin
		if (srst_i) begin
			halted_q <= 1'b0;
		end else if (mem_wr) begin
			halted_q <= 1'b1;
		end else if (restart) begin
			halted_q <= 1'b0;
		end
	end

	// Read pipeline valid flags
	always @(posedge clock_i) begin
		if (srst_i) begin
			rd_valid_q <= 1'b0;
			out_valid_q <= 1'b0;
		end else begin
			rd_valid_q <= mem_en && !mem_wr && !halted_q;
			out_valid_q <= rd_valid_q;
		end
	end

	// Sweep engine next state
	always @* begin
		state_d = state_q;
		addr_d = addr_q;
		timer_d = timer_q;
		acc_clear_d = acc_clear_o;
		if (!mem_en || !seg_mode) begin
			state_d = ST_IDLE;
			acc_clear_d = 1'b0;
		end else if (restart || (state_q == ST_IDLE)) begin
			addr_d = bidir ? start0 : start_addr;
			timer_d = rate;
			acc_clear_d = 1'b0;
			if (mode == `DRPS_MODE_DIRECT) begin
				state_d = ST_DWELL;
			end else begin
				state_d = ST_RUN;
			end
		end else begin
			case (state_q)
			ST_RUN: begin
				if (tick) begin
					timer_d = rate;
				end else begin
					timer_d = timer_q - 16'd1;
				end
				case (mode)
				`DRPS_MODE_RAMPUP: begin
					// Timer keeps running at the end so the clear lands one period later
					if (addr_q == end_addr) begin
						state_d = no_dwell ? ST_CLEAR : ST_DWELL;
					end else if (tick) begin
						addr_d = addr_q + 10'd1;
					end
				end
				`DRPS_MODE_BIDIR: begin
					if (tick && dir_up && (addr_q != end0)) begin
						addr_d = addr_q + 10'd1;
					end else if (tick && !dir_up && (addr_q != start0)) begin
						addr_d = addr_q - 10'd1;
					end
				end
				`DRPS_MODE_RECIRC: begin
					if (tick && (addr_q == end_addr)) begin
						addr_d = start_addr;
					end else if (tick) begin
						addr_d = addr_q + 10'd1;
					end
				end
				default: begin
					// Continuous bidirectional steps up and holds at the end
					if (tick && (addr_q != end_addr)) begin
						addr_d = addr_q + 10'd1;
					end
				end
				endcase
			end
			ST_CLEAR: begin
				if (tick) begin
					timer_d = rate;
					acc_clear_d = 1'b1;
					addr_d = start_addr;
					state_d = ST_DWELL;
				end else begin
					timer_d = timer_q - 16'd1;
				end
			end
			ST_DWELL: begin
				// Hold until an update or profile change
				state_d = ST_DWELL;
			end
			default: begin
				state_d = ST_IDLE;
			end
			endcase
		end
	end

	// Sweep engine registers
	always @(posedge clock_i) begin
		if (srst_i) begin
			state_q <= ST_IDLE;
			addr_q <= 10'h000;
			timer_q <= `DRPS_TIMER_RESET;
			acc_clear_o <= 1'b0;
		end else begin
			state_q <= state_d;
			addr_q <= addr_d;
			timer_q <= timer_d;
			acc_clear_o <= acc_clear_d;
		end
	end

	// Routing of memory data to the accumulator or the phase adder
	always @* begin
		tuning_word_d = tuning_word_o;
		phase_word_d = phase_word_o;
		if (mem_en && dest_phase) begin
			tuning_word_d = ftw_q;
			if (out_valid_q) begin
				phase_word_d = mem_rd_q[`DRPS_PHASE_HI:`DRPS_PHASE_LO];
			end
		end else if (mem_en) begin
			phase_word_d = pow_q;
			if (out_valid_q) begin
				// Accumulator is not cleared, so phase stays continuous
				tuning_word_d = mem_rd_q;
			end
		end else begin
			tuning_word_d = ftw_q;
			phase_word_d = pow_q;
		end
	end

	// Routed word registers
	always @(posedge clock_i) begin
		if (srst_i) begin
			tuning_word_o <= `DRPS_FTW_RESET;
			phase_word_o <= `DRPS_POW_RESET;
		end else begin
			tuning_word_o <= tuning_word_d;
			phase_word_o <= phase_word_d;
		end
	end

	// Address, read status and segment registers
	always @(posedge clock_i) begin
		if (srst_i) begin
			mem_addr_o <= 10'h000;
			mem_reading_o <= 1'b0;
			segment_o <= 2'h0;
		end else begin
			mem_addr_o <= addr_q;
			mem_reading_o <= rd_valid_q;
			segment_o <= seg;
		end
	end
endmodule // drps_sequencer

/* File: verification/drps_checker.sv */
// Port checker for the sequencer.
// Assumes one clock, sync high reset.
`timescale 1ns/1ps
module drps_checker (
	// Clock and inputs
	input wire clock_i,
	input wire srst_i,
	input wire reg_wr_i,
	input wire [7:0] reg_addr_i,
	input wire [31:0] primary_control_register_i,
	input wire io_update_i,
	input wire [1:0] profile_select_pins_i,
	// Outputs
	input wire acc_clear_o,
	input wire mem_reading_o,
	input wire [1:0] segment_o,
	input wire load_done_o
);
	// Memory enable
	wire mem_en = primary_control_register_i[31];
	default clocking @(posedge clock_i); endclocking
	default disable iff (srst_i);
	sequence s_mwr; reg_wr_i && reg_addr_i == 8'h0b; endsequence
	sequence s_quiet; $stable(profile_select_pins_i) [*4]; endsequence
	property p_rst; disable iff (1'b0) srst_i |=> !acc_clear_o && !mem_reading_o; endproperty
	property p_idle; !mem_en && !$past(mem_en) && !$past(mem_en, 2) |-> !mem_reading_o; endproperty
	property p_halt; s_mwr |-> ##2 !mem_reading_o; endproperty
	property p_seg; s_quiet |-> segment_o == profile_select_pins_i; endproperty
	property p_upd; io_update_i && mem_en && !reg_wr_i |-> ##[1:3] mem_reading_o; endproperty
	property p_clr;
		$fell(acc_clear_o) |-> $past(io_update_i) || $past(io_update_i, 2) || $changed(segment_o) || !mem_en;
	endproperty
	property p_mem; acc_clear_o |-> $past(mem_en); endproperty
	property p_done; load_done_o |-> $past(reg_wr_i && reg_addr_i == 8'h0b); endproperty
	a_rst: assert property (p_rst) else $error("reset");
	a_idle: assert property (p_idle) else $error("idle");
	a_halt: assert property (p_halt) else $error("halt");
	a_seg: assert property (p_seg) else $error("segment");
	a_upd: assert property (p_upd) else $error("restart");
	a_clr: assert property (p_clr) else $error("clear drop");
	a_mem: assert property (p_mem) else $error("clear");
	a_done: assert property (p_done) else $error("done");
endmodule // drps_checker
bind drps_sequencer drps_checker u_chk (.clock_i, .srst_i, .reg_wr_i, .reg_addr_i, .primary_control_register_i,
	.io_update_i, .profile_select_pins_i, .acc_clear_o, .mem_reading_o, .segment_o, .load_done_o);

/* File: verification/drps_host.sv */
// Host model driving the sequencer.
// Assumes bench calls; changes at falling edges.
`timescale 1ns/1ps
module drps_host (
	// Clock
	input wire clock_i,
	// Drive
	output logic reg_wr_o,
	output logic [7:0] reg_addr_o,
	output logic [39:0] reg_wdata_o,
	output logic [31:0] ctl_o,
	output logic io_update_o,
	output logic [1:0] pins_o
);
	// Idle, single tone
	initial {reg_wr_o, reg_addr_o, reg_wdata_o, ctl_o, io_update_o, pins_o} = '0;
	// One write, data scrambled after
	task wr(input logic [7:0] a, input logic [39:0] d);
		@(negedge clock_i);
		{reg_wr_o, reg_addr_o, reg_wdata_o} = {1'b1, a, d};
		@(negedge clock_i);
		{reg_wr_o, reg_wdata_o} = {1'b0, ~d};
	endtask
	// Segment word, nonzero rate
	task seg(input logic [1:0] i, input logic [15:0] r, input logic [9:0] s, e, input logic [2:0] m, input logic n);
		wr(8'h07 + 8'(i), {r, e[7:0], s[5:0], e[9:8], m, n, s[9:6]});
	endtask
	// Update strobe
	task upd;
		@(negedge clock_i);
		io_update_o = 1'b1;
		@(negedge clock_i);
		io_update_o = 1'b0;
	endtask
endmodule // drps_host

/* File: verification/drps_sequencer_tb_top.sv */
// Bench for the sequencer.
// Assumes the host model drives all but clock and reset.
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin failures++; $display("Error %0t mismatch %h", $time, g); end end
module drps_sequencer_tb_top;
	logic clock_i = 1'b0;
	logic srst_i = 1'b1;
	wire reg_wr_i, io_update_i, acc_clear_o, mem_reading_o, load_done_o;
	wire [7:0] reg_addr_i;
	wire [39:0] reg_wdata_i;
	wire [31:0] primary_control_register_i, tuning_word_o;
	wire [1:0] profile_select_pins_i, segment_o;
	wire [13:0] phase_word_o;
	wire [9:0] mem_addr_o;
	int failures = 0;
	int n_checks = 0;
	logic [31:0] frequency_tuning_word = 32'h12345678;
	logic [31:0] w [3] = '{32'hc0de0001, 32'h5a5a1234, 32'h0f0f8888};
	// 25 MHz clock
	initial forever #20 clock_i = ~clock_i;
	drps_host u_host (.clock_i, .reg_wr_o(reg_wr_i), .reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i),
		.ctl_o(primary_control_register_i), .io_update_o(io_update_i), .pins_o(profile_select_pins_i));
	drps_sequencer u_dut (.clock_i, .srst_i, .reg_wr_i, .reg_addr_i, .reg_wdata_i, .primary_control_register_i,
		.io_update_i, .profile_select_pins_i, .tuning_word_o, .phase_word_o, .acc_clear_o, .mem_addr_o,
		.mem_reading_o, .segment_o, .load_done_o);
	task wt(input int n);
		repeat (n) @(negedge clock_i);
	endtask
	task complete_run;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// Hang guard
	initial begin
		#1000000;
		failures++;
		complete_run;
	end
	// Main sequence
	initial begin
		wt(8);
		srst_i = 1'b0;
		`CHK(tuning_word_o, 32'h0)
		u_host.wr(8'h04, {8'h00, frequency_tuning_word});
		u_host.wr(8'h05, 40'h1abc);
		u_host.upd;
		wt(4);
		`CHK(tuning_word_o, frequency_tuning_word)
		$display("tone end");
		u_host.seg(2'h1, 16'h0002, 10'h104, 10'h106, 3'h1, 1'b0);
		u_host.pins_o = 2'h1;
		wt(5);
		`CHK(segment_o, 2'h1)
		for (int i = 0; i < 3; i++) begin
			`CHK(load_done_o, 1'b0)
			u_host.wr(8'h0b, {8'h00, w[i]});
		end
		`CHK(load_done_o, 1'b1)
		$display("load end");
		u_host.ctl_o = 32'h80000000;
		u_host.upd;
		wt(2);
		`CHK(mem_addr_o, 10'h104)
		wt(1);
		`CHK(mem_addr_o, 10'h105)
		wt(8);
		`CHK(mem_addr_o, 10'h106)
		`CHK(tuning_word_o, w[2])
		`CHK(phase_word_o, 14'h1abc)
		`CHK(mem_reading_o, 1'b1)
		u_host.wr(8'h0b, {8'h00, w[0]});
		wt(1);
		`CHK(mem_reading_o, 1'b0)
		$display("ramp end");
		u_host.seg(2'h1, 16'h0002, 10'h104, 10'h106, 3'h0, 1'b1);
		u_host.ctl_o = 32'hc0000000;
		u_host.upd;
		wt(8);
		`CHK(mem_addr_o, 10'h104)
		`CHK(phase_word_o, w[0][31:18])
		`CHK(tuning_word_o, frequency_tuning_word)
		$display("direct end");
		u_host.seg(2'h1, 16'h0002, 10'h104, 10'h106, 3'h1, 1'b1);
		u_host.ctl_o = 32'h80000000;
		u_host.upd;
		wt(12);
		`CHK(acc_clear_o, 1'b1)
		`CHK(mem_addr_o, 10'h104)
		u_host.upd;
		wt(2);
		`CHK(acc_clear_o, 1'b0)
		$display("no dwell end");
		complete_run;
	end
endmodule // drps_sequencer_tb_top
